// file: rtl/periph_irq_defines.svh
`ifndef PERIPH_IRQ_DEFINES_SVH
`define PERIPH_IRQ_DEFINES_SVH

// Register byte addresses (printed offsets are multiples of four)
`define FLAGS_OFFSET      8'h0C
`define ENABLES_OFFSET    8'h8C
`define CORE_CTRL_OFFSET  8'h10
`define SUMMARY_OFFSET    8'h14

// Flag and enable bit positions
`define BIT_PARALLEL      7
`define BIT_ADC           6
`define BIT_SERIAL_RX     5
`define BIT_SERIAL_TX     4
`define BIT_SYNC_SERIAL   3
`define BIT_CAPCMP        2
`define BIT_TIMER_B       1
`define BIT_TIMER_A       0

// Core control bit positions
`define BIT_GLOBAL_PERIPH 6
`define BIT_GLOBAL_IRQ    7

// Software-writable flag bits (receive and transmit excluded)
`define FLAGS_WR_MASK     8'hCF

// Reset values
`define FLAGS_RESET       8'h00
`define ENABLES_RESET     8'h00
`define CORE_CTRL_RESET   8'h00

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: rtl/periph_irq_pkg.sv
package periph_irq_pkg;
   typedef logic [7:0] reg8_t;
   typedef enum logic [1:0] {
      SYNC_SPI,
      SYNC_I2C_SLAVE,
      SYNC_I2C_MASTER,
      SYNC_IDLE_BUS
   } sync_event_t;
endpackage

// file: rtl/peripheral_irq_enable_flags.sv
// What this block does
// R01: No peripheral request reaches the CPU unless global peripheral enable is set.
// R02: Flags set on source events regardless of their enable or global enable.
// R03: Software should clear flags before setting their enables.
// R04: Enable register at 8Ch, eight read/write bits, reset zero.
// R05: Flag register at 0Ch; receive and transmit flags read-only; reset zero.
// R06: On 28-pin parts software keeps parallel-port enable and flag clear.
// R07: Parallel-port flag sets on external port read or write; sticky.
// R08: A/D flag sets when a conversion completes; sticky.
// R09: Receive flag mirrors receive buffer full; not writable.
// R10: Transmit flag mirrors transmit buffer empty; not writable.
// R11: Sync serial flag sets on SPI, I2C slave, master or idle-bus events.
// R12: Capture/compare flag sets on capture or compare match, not in PWM.
// R13: Timer-b flag sets on period match; sticky.
// R14: Timer-a flag sets on overflow; sticky.
// R15: Sync serial flag stays set until software clears it.
// R16: Request when any flag and enable match, with both global enables set.
// R17: Source event in the same cycle as a flag write wins.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "periph_irq_defines.svh"

module peripheral_irq_enable_flags (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Peripheral events, one-cycle pulses, and the PWM mode level
   input  wire logic        parallelPortAccess,
   input  wire logic        adcDone,
   input  wire logic        syncSerialEvent,
   input  wire logic        capCmpEvent,
   input  wire logic        pwmMode,
   input  wire logic        timerBMatch,
   input  wire logic        timerAOverflow,
   // Serial buffer levels
   input  wire logic        serialRxFull,
   input  wire logic        serialTxEmpty,
   // Interrupt output
   output logic             periphIrq
);

   periph_irq_pkg::reg8_t flags_ff;
   periph_irq_pkg::reg8_t enables_ff;
   periph_irq_pkg::reg8_t coreCtrl_ff;
   logic [7:0]            wrAddr_ff;
   logic [31:0]           wrData_ff;
   logic [3:0]            wrStrb_ff;
   logic                  awHeld_ff;
   logic                  wHeld_ff;
   logic                  periphIrq_ff;

   periph_irq_pkg::reg8_t nxt_flags;
   periph_irq_pkg::reg8_t eventSet;
   logic                  wrFire;
   logic                  wrLow;
   logic                  nxt_irq;

   function automatic logic isMapped(input logic [7:0] addr);
      isMapped = (addr == `FLAGS_OFFSET) || (addr == `ENABLES_OFFSET) ||
                 (addr == `CORE_CTRL_OFFSET) || (addr == `SUMMARY_OFFSET);
   endfunction

   // Write channel: address and data may come in either order
   assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
   assign wrLow  = wrFire && wrStrb_ff[0];

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         awHeld_ff     <= 1'b0;
         wHeld_ff      <= 1'b0;
         wrAddr_ff     <= 8'h00;
         wrData_ff     <= 32'h0000_0000;
         wrStrb_ff     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            wrAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff  <= 1'b1;
            wrData_ff <= s_axi_wdata;
            wrStrb_ff <= s_axi_wstrb;
         end
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= isMapped(wrAddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld_ff    <= 1'b0;
            wHeld_ff     <= 1'b0;
         end
      end
   end

   // Read channel
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= isMapped(s_axi_araddr) ? `RESP_OKAY
                                                    : `RESP_SLVERR;
            case (s_axi_araddr)
               `FLAGS_OFFSET:     s_axi_rdata <= {24'h000000, flags_ff};
               `ENABLES_OFFSET:   s_axi_rdata <= {24'h000000, enables_ff};
               `CORE_CTRL_OFFSET: s_axi_rdata <= {24'h000000, coreCtrl_ff};
               `SUMMARY_OFFSET:   s_axi_rdata <= {31'h0000_0000,
                                                  periphIrq_ff};
               default:           s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Enable and core control registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         enables_ff  <= `ENABLES_RESET;
         coreCtrl_ff <= `CORE_CTRL_RESET;
      end else if (wrLow) begin
         if (wrAddr_ff == `ENABLES_OFFSET)
            enables_ff <= wrData_ff[7:0]; // R04
         if (wrAddr_ff == `CORE_CTRL_OFFSET)
            coreCtrl_ff <= wrData_ff[7:0] &
                           8'(1 << `BIT_GLOBAL_PERIPH | 1 << `BIT_GLOBAL_IRQ);
      end
   end

   // Sticky events gathered into one set vector
   always_comb begin
      eventSet                   = 8'h00;
      eventSet[`BIT_PARALLEL]    = parallelPortAccess; // R07
      eventSet[`BIT_ADC]         = adcDone; // R08
      eventSet[`BIT_SYNC_SERIAL] = syncSerialEvent; // R11
      eventSet[`BIT_CAPCMP]      = capCmpEvent && !pwmMode; // R12
      eventSet[`BIT_TIMER_B]     = timerBMatch; // R13
      eventSet[`BIT_TIMER_A]     = timerAOverflow; // R14
   end

   always_comb begin
      nxt_flags = flags_ff;
      if (wrLow && wrAddr_ff == `FLAGS_OFFSET)
         nxt_flags = (flags_ff & ~`FLAGS_WR_MASK) |
                     (wrData_ff[7:0] & `FLAGS_WR_MASK); // R05
      // Set wins over a same-cycle software write
      nxt_flags = nxt_flags | eventSet; // R02 R15 R17
      // Buffer status flags are live levels, not latched
      nxt_flags[`BIT_SERIAL_RX] = serialRxFull; // R09
      nxt_flags[`BIT_SERIAL_TX] = serialTxEmpty; // R10
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         flags_ff <= `FLAGS_RESET;
      else
         flags_ff <= nxt_flags;
   end

   // Request gated by both global enables
   assign nxt_irq = (|(flags_ff & enables_ff)) && // R16
                    coreCtrl_ff[`BIT_GLOBAL_PERIPH] && // R01
                    coreCtrl_ff[`BIT_GLOBAL_IRQ];

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         periphIrq_ff <= 1'b0;
      else
         periphIrq_ff <= nxt_irq;
   end

   assign periphIrq = periphIrq_ff;

   property p_no_periph_enable;
      @(posedge core_clk) disable iff (!nrst)
      !coreCtrl_ff[`BIT_GLOBAL_PERIPH] |=> !periphIrq;
   endproperty
   a_no_periph_enable: assert property (p_no_periph_enable) // R01
      else $error("request without peripheral enable");

   property p_event_sets;
      @(posedge core_clk) disable iff (!nrst)
      timerAOverflow |=> flags_ff[`BIT_TIMER_A];
   endproperty
   a_event_sets: assert property (p_event_sets) // R02
      else $error("timer overflow flag not set");

   property p_adc_sticky;
      @(posedge core_clk) disable iff (!nrst)
      adcDone ##1 !(wrLow && wrAddr_ff == `FLAGS_OFFSET)
         |=> flags_ff[`BIT_ADC];
   endproperty
   a_adc_sticky: assert property (p_adc_sticky) // R08
      else $error("adc flag lost");

   property p_rx_mirror;
      @(posedge core_clk) disable iff (!nrst)
      ##1 flags_ff[`BIT_SERIAL_RX] == $past(serialRxFull);
   endproperty
   a_rx_mirror: assert property (p_rx_mirror) // R09
      else $error("rx flag mismatch");

   property p_tx_mirror;
      @(posedge core_clk) disable iff (!nrst)
      ##1 flags_ff[`BIT_SERIAL_TX] == $past(serialTxEmpty);
   endproperty
   a_tx_mirror: assert property (p_tx_mirror) // R10
      else $error("tx flag mismatch");

   property p_pwm_ignored;
      @(posedge core_clk) disable iff (!nrst)
      capCmpEvent && pwmMode && !flags_ff[`BIT_CAPCMP] &&
      !(wrLow && wrAddr_ff == `FLAGS_OFFSET) |=> !flags_ff[`BIT_CAPCMP];
   endproperty
   a_pwm_ignored: assert property (p_pwm_ignored) // R12
      else $error("capture flag set in pwm mode");

   property p_set_wins;
      @(posedge core_clk) disable iff (!nrst)
      syncSerialEvent && wrLow && wrAddr_ff == `FLAGS_OFFSET
         |=> flags_ff[`BIT_SYNC_SERIAL];
   endproperty
   a_set_wins: assert property (p_set_wins) // R17
      else $error("event lost against write");

   property p_request;
      @(posedge core_clk) disable iff (!nrst)
      (|(flags_ff & enables_ff)) && coreCtrl_ff[`BIT_GLOBAL_PERIPH] &&
      coreCtrl_ff[`BIT_GLOBAL_IRQ] |=> periphIrq;
   endproperty
   a_request: assert property (p_request) // R16
      else $error("request missing");

   property p_parallel_sets;
      @(posedge core_clk) disable iff (!nrst)
      parallelPortAccess |=> flags_ff[`BIT_PARALLEL];
   endproperty
   a_parallel_sets: assert property (p_parallel_sets) // R07
      else $error("parallel port flag not set");

   property p_adc_sets;
      @(posedge core_clk) disable iff (!nrst)
      adcDone |=> flags_ff[`BIT_ADC];
   endproperty
   a_adc_sets: assert property (p_adc_sets) // R08
      else $error("adc flag not set");

   property p_sync_sets;
      @(posedge core_clk) disable iff (!nrst)
      syncSerialEvent |=> flags_ff[`BIT_SYNC_SERIAL];
   endproperty
   a_sync_sets: assert property (p_sync_sets) // R11
      else $error("sync serial flag not set");

   property p_capcmp_sets;
      @(posedge core_clk) disable iff (!nrst)
      capCmpEvent && !pwmMode |=> flags_ff[`BIT_CAPCMP];
   endproperty
   a_capcmp_sets: assert property (p_capcmp_sets) // R12
      else $error("capture flag not set");

   property p_timer_b_sets;
      @(posedge core_clk) disable iff (!nrst)
      timerBMatch |=> flags_ff[`BIT_TIMER_B];
   endproperty
   a_timer_b_sets: assert property (p_timer_b_sets) // R13
      else $error("timer match flag not set");

   property p_flags_sticky;
      @(posedge core_clk) disable iff (!nrst)
      !(wrLow && wrAddr_ff == `FLAGS_OFFSET)
         |=> ($past(flags_ff) & ~flags_ff & `FLAGS_WR_MASK) == 8'h00;
   endproperty
   a_flags_sticky: assert property (p_flags_sticky) // R15
      else $error("flag dropped without software write");

   property p_flag_write;
      @(posedge core_clk) disable iff (!nrst)
      wrLow && wrAddr_ff == `FLAGS_OFFSET && eventSet == 8'h00
         |=> (flags_ff & `FLAGS_WR_MASK) ==
             ($past(wrData_ff[7:0]) & `FLAGS_WR_MASK);
   endproperty
   a_flag_write: assert property (p_flag_write) // R05
      else $error("flag write not applied");

   property p_enables_write;
      @(posedge core_clk) disable iff (!nrst)
      wrLow && wrAddr_ff == `ENABLES_OFFSET
         |=> enables_ff == $past(wrData_ff[7:0]);
   endproperty
   a_enables_write: assert property (p_enables_write) // R04
      else $error("enable write not applied");

   property p_enables_hold;
      @(posedge core_clk) disable iff (!nrst)
      !(wrLow && wrAddr_ff == `ENABLES_OFFSET) |=> $stable(enables_ff);
   endproperty
   a_enables_hold: assert property (p_enables_hold) // R04
      else $error("enables changed without write");

   property p_no_global_irq;
      @(posedge core_clk) disable iff (!nrst)
      !coreCtrl_ff[`BIT_GLOBAL_IRQ] |=> !periphIrq;
   endproperty
   a_no_global_irq: assert property (p_no_global_irq) // R16
      else $error("request without global enable");

   property p_no_match;
      @(posedge core_clk) disable iff (!nrst)
      (flags_ff & enables_ff) == 8'h00 |=> !periphIrq;
   endproperty
   a_no_match: assert property (p_no_match) // R16
      else $error("request without enabled flag");

   property p_set_while_masked;
      @(posedge core_clk) disable iff (!nrst)
      adcDone && !coreCtrl_ff[`BIT_GLOBAL_IRQ] |=> flags_ff[`BIT_ADC];
   endproperty
   a_set_while_masked: assert property (p_set_while_masked) // R02
      else $error("flag blocked by global enable");

endmodule // peripheral_irq_enable_flags

// file: verif/periph_event_model.sv
`timescale 1ns/1ps
module periph_event_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // Bench requests, bit order of the flag register
   input  wire logic [7:0] fire,
   // Events and buffer levels toward the block
   output logic            parallelPortAccess,
   output logic            adcDone,
   output logic            serialRxFull,
   output logic            serialTxEmpty,
   output logic            syncSerialEvent,
   output logic            capCmpEvent,
   output logic            timerBMatch,
   output logic            timerAOverflow
);
   logic [7:0] evt_ff;
   // Registered, so events change only on the sampling edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) evt_ff <= 8'h00;
      else evt_ff <= fire;
   end
   assign parallelPortAccess = evt_ff[7];
   assign adcDone            = evt_ff[6];
   assign serialRxFull       = evt_ff[5];
   assign serialTxEmpty      = evt_ff[4];
   assign syncSerialEvent    = evt_ff[3];
   assign capCmpEvent        = evt_ff[2];
   assign timerBMatch        = evt_ff[1];
   assign timerAOverflow     = evt_ff[0];
endmodule // periph_event_model

// file: verif/peripheral_irq_enable_flags_bench.sv
`timescale 1ns/1ps
`include "periph_irq_defines.svh"
module peripheral_irq_enable_flags_bench;
   logic        core_clk      = 1'h0;
   logic        nrst          = 1'h0;
   logic [7:0]  s_axi_awaddr  = 8'h00;
   logic [7:0]  s_axi_araddr  = 8'h00;
   logic [31:0] s_axi_wdata   = 32'h0;
   logic [3:0]  s_axi_wstrb   = 4'hF;
   logic        s_axi_awvalid = 1'h0;
   logic        s_axi_wvalid  = 1'h0;
   logic        s_axi_bready  = 1'h0;
   logic        s_axi_arvalid = 1'h0;
   logic        s_axi_rready  = 1'h0;
   logic        pwmMode       = 1'h0;
   logic [7:0]  fire          = 8'h00;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, periphIrq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   logic        parallelPortAccess, adcDone, serialRxFull, serialTxEmpty;
   logic        syncSerialEvent, capCmpEvent, timerBMatch, timerAOverflow;
   logic [7:0]  lvl, en, ctl, ev, ef;
   int          err_count = 0;
   int          checked   = 0;

   always #25 core_clk = ~core_clk;

   peripheral_irq_enable_flags DUT (.core_clk, .nrst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .parallelPortAccess, .adcDone, .syncSerialEvent, .capCmpEvent,
      .pwmMode, .timerBMatch, .timerAOverflow, .serialRxFull,
      .serialTxEmpty, .periphIrq);
   periph_event_model model (.core_clk, .nrst, .fire, .parallelPortAccess,
      .adcDone, .serialRxFull, .serialTxEmpty, .syncSerialEvent,
      .capCmpEvent, .timerBMatch, .timerAOverflow);

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic tmo(int n);
      if (n >= 40) begin
         err_count++;
         close_out();
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] v);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      tmo(n);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge core_clk);
   endtask

   task automatic rd(logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      tmo(n);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge core_clk);
   endtask

   // Bits 5 and 4 of lvl stay up as buffer levels; m pulses once
   task automatic pulse(logic [7:0] m);
      fire <= lvl | m;
      @(posedge core_clk);
      fire <= lvl;
      repeat (2) @(posedge core_clk);
   endtask

   function automatic logic [7:0] expFlags(logic [7:0] e, logic p,
                                           logic [7:0] l);
      return (e & (p ? 8'hCB : 8'hCF)) | l;
   endfunction

   function automatic logic expIrq(logic [7:0] f, e, c);
      return (|(f & e)) & c[7] & c[6];
   endfunction

   initial begin
      lvl = 8'h00;
      void'($urandom(32'hA0AB));
      repeat (8) @(posedge core_clk);
      nrst <= 1'h1;
      @(posedge core_clk);
      rd(`FLAGS_OFFSET);
      chk("flags reset", d, 32'h0);
      rd(`ENABLES_OFFSET);
      chk("enables reset", d, 32'h0);
      rd(8'h40);
      chk("unmapped read", {d[29:0], r}, {30'h0, `RESP_SLVERR});
      wr(8'h40, 8'hFF);
      chk("unmapped write", r, `RESP_SLVERR);
      wr(`ENABLES_OFFSET, 8'hFF);
      chk("write resp", r, `RESP_OKAY);
      // Low byte strobe off: the write must leave the register alone
      s_axi_wstrb <= 4'hE;
      wr(`ENABLES_OFFSET, 8'h00);
      s_axi_wstrb <= 4'hF;
      rd(`ENABLES_OFFSET);
      chk("enables rw", d, 32'hFF);
      wr(`CORE_CTRL_OFFSET, 8'hFF);
      rd(`CORE_CTRL_OFFSET);
      chk("core ctrl", d, 32'hC0);
      wr(`FLAGS_OFFSET, 8'hFF);
      rd(`FLAGS_OFFSET);
      chk("flags rw", d, 32'hCF);
      $display("test registers done");
      // First four rounds walk every combination of the two globals
      for (int i = 0; i < 24; i++) begin
         en = (i < 4) ? 8'hFF : 8'($urandom());
         ctl = (i < 4) ? {i[1:0], 6'h0} : 8'($urandom()) & 8'hC0;
         ev = (i < 4) ? 8'h01 : 8'($urandom()) & 8'hCF;
         lvl = 8'($urandom()) & 8'h30;
         pwmMode <= 1'($urandom());
         wr(`FLAGS_OFFSET, 8'h00);
         wr(`ENABLES_OFFSET, en);
         wr(`CORE_CTRL_OFFSET, ctl);
         pulse(ev);
         ef = expFlags(ev, pwmMode, lvl);
         rd(`FLAGS_OFFSET);
         chk("flags", d, {24'h0, ef});
         chk("irq", periphIrq, expIrq(ef, en, ctl));
         rd(`SUMMARY_OFFSET);
         chk("summary", d, {31'h0, expIrq(ef, en, ctl)});
         rd(`FLAGS_OFFSET);
         chk("flags sticky", d, {24'h0, ef});
      end
      $display("test events done");
      // Sync serial and timer-a events held high across the clearing write
      lvl = 8'h09;
      pulse(8'h02);
      wr(`FLAGS_OFFSET, 8'h00);
      lvl = 8'h00;
      pulse(8'h00);
      rd(`FLAGS_OFFSET);
      chk("event beats clear", d, 32'h09);
      $display("test collision done");
      wr(`ENABLES_OFFSET, 8'h7F);
      wr(`FLAGS_OFFSET, 8'h00);
      pulse(8'h4B);
      rd(`FLAGS_OFFSET);
      chk("reserved kept clear", d, 32'h4B);
      rd(`ENABLES_OFFSET);
      chk("reserved enable clear", d, 32'h7F);
      $display("test reserved done");
      close_out();
   end
endmodule // peripheral_irq_enable_flags_bench
